//--- hw/spg_cfg.svh
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH
// power-up access delay in microseconds and its cycle count at 100 MHz
`define SPG_CLK_MHZ 100
`define SPG_ACCESS_DELAY_US 200
`define SPG_ACCESS_DELAY_CYC (`SPG_ACCESS_DELAY_US * `SPG_CLK_MHZ)
// internal power-on reset settle time, cycles
`define SPG_POR_CYC 16
// pulses needed in a hardware reset sequence
`define SPG_HWRST_PULSES 4
`endif

//--- hw/spg_pkg.sv
package spg_pkg;
    typedef enum logic [1:0] {
        SPG_MODE0 = 2'b00,
        SPG_MODE3 = 2'b11
    } spg_mode_t;

    typedef enum {
        SPG_POR,
        SPG_STANDBY,
        SPG_ACTIVE
    } spg_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic rst_data;
    } spg_pins_t;
endpackage

//--- hw/spg_gate.sv
// Behaviour
// - output pin undriven after power or reset
// - commands need a chip-select falling edge
// - clock level at select picks mode
// - during power-on reset ignore all commands
// - hardware reset sequence restarts power-on reset
`timescale 1ns/100ps
`include "spg_cfg.svh"
module spg_gate #(
    parameter int POR_CYC = `SPG_POR_CYC,
    parameter int HWRST_PULSES = `SPG_HWRST_PULSES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire spg_pkg::spg_pins_t pins_i,
    input wire logic out_req_i,
    input wire logic out_bit_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic por_busy_o,
    output logic cmd_open_o,
    output logic cs_fall_o,
    output spg_pkg::spg_mode_t mode_o
);
    // a select held low through reset shows up as a fall two edges after
    // release; power-on reset must outlast the sync so that fall is dropped
    if (POR_CYC < 3) begin : g_por_short
        $error("spg_gate: POR_CYC below synchroniser latency");
    end
    // the sequence counter is four bits wide
    if (HWRST_PULSES < 1 || HWRST_PULSES > 15) begin : g_pulse_range
        $error("spg_gate: HWRST_PULSES out of range");
    end

    spg_pkg::spg_pins_t m_q, s_q, p_q;
    spg_pkg::spg_state_t st_q;
    logic [$clog2(POR_CYC+1)-1:0] por_cnt_q;
    logic [3:0] rst_cnt_q;
    logic cs_fall, cs_rise, rd_rise, hw_rst;

    // a select edge counts only once power-on reset has let go
    function automatic logic edge_counts(input logic fall,
            input spg_pkg::spg_state_t st);
        return fall && st != spg_pkg::SPG_POR;
    endfunction

    // two-flop sync, then one more stage for edge finding
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            m_q <= '1;
            s_q <= '1;
            p_q <= '1;
        end else begin
            m_q <= pins_i;
            s_q <= m_q;
            p_q <= s_q;
        end
    end

    assign cs_fall = p_q.cs_n & ~s_q.cs_n;
    assign cs_rise = ~p_q.cs_n & s_q.cs_n;
    assign rd_rise = ~p_q.rst_data & s_q.rst_data;
    // hardware reset: data pulses while select stays high, clock low
    assign hw_rst = (rst_cnt_q == 4'(HWRST_PULSES - 1)) && rd_rise && s_q.cs_n
        && !s_q.sck;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_cnt_q <= 4'h0;
        end else if (!s_q.cs_n || s_q.sck || hw_rst) begin
            rst_cnt_q <= 4'h0;
        end else if (rd_rise) begin
            rst_cnt_q <= rst_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= spg_pkg::SPG_POR;
            por_cnt_q <= '0;
        end else if (hw_rst) begin
            st_q <= spg_pkg::SPG_POR;
            por_cnt_q <= '0;
        end else begin
            unique case (st_q)
                spg_pkg::SPG_POR: begin
                    // pins ignored here
                    if (por_cnt_q == ($bits(por_cnt_q))'(POR_CYC - 1)) begin
                        st_q <= spg_pkg::SPG_STANDBY;
                    end else begin
                        por_cnt_q <= por_cnt_q + 1'b1;
                    end
                end
                spg_pkg::SPG_STANDBY: begin
                    // select already low at release is not an edge
                    if (cs_fall) begin
                        st_q <= spg_pkg::SPG_ACTIVE;
                    end
                end
                spg_pkg::SPG_ACTIVE: begin
                    if (cs_rise) begin
                        st_q <= spg_pkg::SPG_STANDBY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_o <= spg_pkg::SPG_MODE0;
            cs_fall_o <= 1'b0;
        end else begin
            cs_fall_o <= edge_counts(cs_fall, st_q);
            if (edge_counts(cs_fall, st_q)) begin
                mode_o <= s_q.sck ? spg_pkg::SPG_MODE3 : spg_pkg::SPG_MODE0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
            por_busy_o <= 1'b1;
            cmd_open_o <= 1'b0;
        end else begin
            // a restart inside power-on reset must not blink busy low
            por_busy_o <= st_q == spg_pkg::SPG_POR || hw_rst;
            cmd_open_o <= st_q == spg_pkg::SPG_ACTIVE && !cs_rise && !hw_rst;
            // drive only inside an opened command that asks for output
            so_oe_n_o <= !(st_q == spg_pkg::SPG_ACTIVE && !s_q.cs_n && out_req_i);
            so_o <= out_bit_i;
        end
    end

    sel_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cs_fall && st_q != spg_pkg::SPG_POR |=> mode_o == ($past(s_q.sck)
        ? spg_pkg::SPG_MODE3 : spg_pkg::SPG_MODE0))
        else $error("mode not taken from clock level");

    por_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q == spg_pkg::SPG_POR |=> !cmd_open_o && so_oe_n_o)
        else $error("activity during power-on reset");

    hiz_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q != spg_pkg::SPG_ACTIVE |=> so_oe_n_o)
        else $error("output driven outside a command");

    need_edge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(cmd_open_o) |-> $past(cs_fall, 2))
        else $error("command opened without select edge");

    hw_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        hw_rst |=> st_q == spg_pkg::SPG_POR ##1 por_busy_o)
        else $error("reset sequence did not restart");

    por_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q == spg_pkg::SPG_POR && !hw_rst
        && por_cnt_q == ($bits(por_cnt_q))'(POR_CYC - 1)
        |=> st_q == spg_pkg::SPG_STANDBY ##1 !cmd_open_o)
        else $error("power-on reset end not standby");

    // a level here would make the partner count one frame twice
    fall_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cs_fall_o |=> !cs_fall_o)
        else $error("select pulse longer than one cycle");

    open_close_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cs_rise |=> !cmd_open_o)
        else $error("command window open after select rise");

    // a select that was already low at release must not open a command
    standby_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q == spg_pkg::SPG_STANDBY && !cs_fall |=> st_q != spg_pkg::SPG_ACTIVE)
        else $error("command opened from standby without an edge");

    busy_track_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q == spg_pkg::SPG_POR |=> por_busy_o)
        else $error("busy flag low during power-on reset");

    por_mute_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q == spg_pkg::SPG_POR |=> !cs_fall_o && $stable(mode_o))
        else $error("select edge taken during power-on reset");

    mode_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !edge_counts(cs_fall, st_q) |=> $stable(mode_o))
        else $error("mode changed without a select edge");

    // the pin may only leave high impedance inside an open command
    drive_open_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !so_oe_n_o |-> cmd_open_o)
        else $error("output driven without an open command");

    hiz_select_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_q.cs_n |=> so_oe_n_o)
        else $error("output driven while select is high");

    req_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !out_req_i |=> so_oe_n_o)
        else $error("output driven without a request");

    seq_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rst_cnt_q < 4'(HWRST_PULSES))
        else $error("reset sequence count overran");

    // any select activity breaks a half-done sequence
    seq_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !s_q.cs_n |=> rst_cnt_q == 4'h0)
        else $error("reset sequence survived a select");

    // the counter parks at its last value once standby is reached
    por_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        por_cnt_q < ($bits(por_cnt_q))'(POR_CYC))
        else $error("power-on reset counter overran");

    // busy must drop so the host knows access is allowed
    busy_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st_q == spg_pkg::SPG_STANDBY && !hw_rst |=> !por_busy_o)
        else $error("busy flag stuck in standby");
endmodule

//--- dv/spg_host.sv
`timescale 1ns/100ps
module spg_host (
    input wire logic clk_i,
    output spg_pkg::spg_pins_t pins_o
);
    initial pins_o = '{cs_n: 1'b1, sck: 1'b0, rst_data: 1'b0};
    // sck low outside frames, set to its idle level ahead of the select fall, 160 ns period inside
    task automatic frame(input logic idle, input int halves);
        // step off the edge on which the previous frame parked sck
        @(posedge clk_i);
        pins_o.sck <= idle;
        repeat (4) @(posedge clk_i);
        pins_o.cs_n <= 1'b0;
        repeat (halves) begin
            repeat (8) @(posedge clk_i);
            pins_o.sck <= ~pins_o.sck;
        end
        repeat (4) @(posedge clk_i);
        pins_o.cs_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        pins_o.sck <= 1'b0;
    endtask
    task automatic hw_reset();
        repeat (4) begin
            repeat (4) @(posedge clk_i);
            pins_o.rst_data <= 1'b1;
            repeat (4) @(posedge clk_i);
            pins_o.rst_data <= 1'b0;
        end
    endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/100ps
`include "spg_cfg.svh"
module testbench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic out_req_i = 1'b0;
    logic out_bit_i = 1'b0;
    logic so_o, so_oe_n_o, por_busy_o, cmd_open_o, cs_fall_o;
    spg_pkg::spg_mode_t mode_o;
    spg_pkg::spg_pins_t pins;
    int fail_count = 0;
    int check_count = 0;
    int falls = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (cs_fall_o === 1'b1) falls++;
    spg_host u_spg_host (.clk_i(clk_i), .pins_o(pins));
    spg_gate u_spg_gate (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins),
        .out_req_i(out_req_i), .out_bit_i(out_bit_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
        .por_busy_o(por_busy_o), .cmd_open_o(cmd_open_o), .cs_fall_o(cs_fall_o),
        .mode_o(mode_o));
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic por_refuse();
        fork
            u_spg_host.frame(1'b0, 4);
            begin
                repeat (6) @(posedge clk_i);
                out_req_i <= 1'b1;
                check(por_busy_o === 1'b1, "not in power-on reset");
                repeat (24) @(posedge clk_i);
                check(so_oe_n_o === 1'b1, "output driven");
                check(cmd_open_o === 1'b0 && por_busy_o === 1'b0, "stale select");
                out_req_i <= 1'b0;
            end
        join
        check(falls == 0, "select edge taken in reset");
    endtask
    task automatic mode_pick(input logic idle);
        int f0;
        f0 = falls;
        fork
            u_spg_host.frame(idle, 6);
            begin
                repeat (12) @(posedge clk_i);
                check(cmd_open_o === 1'b1, "no command window");
                check(mode_o === (idle ? spg_pkg::SPG_MODE3 : spg_pkg::SPG_MODE0), "mode");
                out_req_i <= 1'b1;
                out_bit_i <= ~idle;
                repeat (2) @(posedge clk_i);
                check(so_oe_n_o === 1'b0 && so_o === ~idle, "output not driven");
                out_req_i <= 1'b0;
            end
        join
        check(falls == f0 + 1 && cmd_open_o === 1'b0, "select edge count");
        check(so_oe_n_o === 1'b1, "output left driven");
    endtask
    task automatic hw_restart();
        u_spg_host.hw_reset();
        repeat (3) @(posedge clk_i);
        check(por_busy_o === 1'b1, "reset sequence ignored");
        repeat (24) @(posedge clk_i);
        check(por_busy_o === 1'b0 && cmd_open_o === 1'b0, "not standby");
        check(so_oe_n_o === 1'b1, "output driven after reset");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        por_refuse();
        repeat (`SPG_ACCESS_DELAY_CYC) @(posedge clk_i);
        mode_pick(1'b1);
        mode_pick(1'b0);
        hw_restart();
        mode_pick(1'b1);
        close_out();
    end
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
endmodule
